// ### src/cspar_pkg.sv
// Shared constants for the camera setting command parser.
package cspar_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] CMD_OFF  = 8'h00;
   localparam logic [7:0] P1_OFF   = 8'h04;
   localparam logic [7:0] P2_OFF   = 8'h08;
   localparam logic [7:0] P3_OFF   = 8'h0c;
   localparam logic [7:0] STAT_OFF = 8'h10;
   localparam logic [7:0] SET_OFF  = 8'h14;
   localparam int         OPC_LSB  = 0;
   localparam int         CNT_LSB  = 8;
   // ==========================================================
   // Command codes
   localparam logic [4:0] OP_WB_MODE   = 5'h00;
   localparam logic [4:0] OP_RED_GAIN  = 5'h01;
   localparam logic [4:0] OP_BLUE_GAIN = 5'h02;
   localparam logic [4:0] OP_OVERLAY   = 5'h03;
   localparam logic [4:0] OP_ONE_PUSH  = 5'h04;
   localparam logic [4:0] OP_COEF      = 5'h05;
   localparam logic [4:0] OP_CORING    = 5'h06;
   localparam logic [4:0] OP_SCALE     = 5'h07;
   localparam logic [4:0] OP_LIMIT     = 5'h08;
   localparam logic [4:0] OP_CRISP     = 5'h09;
   localparam logic [4:0] OP_EDGE_EN   = 5'h0a;
   localparam logic [4:0] OP_MATRIX    = 5'h0b;
   localparam logic [4:0] OP_TONE_MODE = 5'h0c;
   localparam logic [4:0] OP_THRESH    = 5'h0d;
   localparam logic [4:0] OP_TABLE     = 5'h0e;
   localparam logic [4:0] OP_MERGE     = 5'h0f;
   localparam logic [4:0] OP_PARTIAL   = 5'h10;
   localparam logic [4:0] OP_TRIG      = 5'h11;
   localparam logic [4:0] OP_BARS      = 5'h12;
   localparam logic [4:0] OP_RAMP      = 5'h13;
   localparam logic [4:0] OP_SPEED     = 5'h14;
   localparam logic [4:0] OP_TBL_DATA  = 5'h15;
   localparam logic [4:0] OP_TBL_QUIT  = 5'h16;
   // ==========================================================
   // Reply codes and field values
   localparam logic [3:0] REP_NONE   = 4'h0;
   localparam logic [3:0] REP_OK     = 4'h1;
   localparam logic [3:0] REP_SYNTAX = 4'h2;
   localparam logic [3:0] REP_AWB    = 4'h8;
   localparam logic [2:0] WB_MANUAL  = 3'h3;
   localparam logic [2:0] WB_ONEPUSH = 3'h4;
   localparam logic [1:0] TONE_BIN   = 2'h3;
   localparam logic [1:0] MTX_WRITE  = 2'h2;
   localparam logic [2:0] SPEED_RST  = 3'h3;
   localparam logic [4:0] PEND_RST   = 5'h0f;
   localparam int         WIN_SPAN   = 16;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 25_000_000;
   localparam int BPS0   = 4800;
   localparam int BPS1   = 9600;
   localparam int BPS2   = 19200;
   localparam int BPS3   = 38400;
   localparam int BPS4   = 57600;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_AWB  = 3'b010,
      ST_TBL  = 3'b100
   } cspar_state_t;
endpackage

// ### src/cspar_top.sv
// Command parser that applies camera image and I/O settings from APB.
`timescale 1ns/1ns
// ==============================================================
// What this block does
// - White balance mode 0..4: three presets, manual, one-push auto.
// - Red and blue gains are signed 8-bit offsets, used in manual only.
// - Overlay flag hides or shows the detection window.
// - One-push run starts only in mode 4, otherwise ignored.
// - While one-push runs, every further command is refused.
// - A one-push run reports exactly one of eight results.
// - Three 7-bit edge coefficients; omitted ones keep their value.
// - Coring thresholds; a lone first value is copied to the second.
// - Enhancement scales; a lone first value is copied to the second.
// - Enhancement limits; a lone lower limit sets the upper one.
// - Crispness level 0..7 is applied to the output.
// - Edge enhancement off forces scale and crispness to zero.
// - Matrix mode 2 writes a 10-bit value at index 0..8.
// - Stored matrix mode changes only for modes 0 and 1.
// - Tone mode: linear, user table, inverted or binary.
// - Threshold 0..1024 acts only in binary tone mode.
// - Table entry from start index enters entry mode; quit leaves it.
// - Vertical binning selectable on monochrome variant only.
// - Partial window needs start below end and span below 16.
// - Trigger source selects link connector or power connector.
// - Test pattern on or off: bars for colour, ramp for mono.
// - Speed codes 0..4 select 4800 to 57600 bits per second.
// - Any out-of-range parameter discards the command with an error.
module cspar_top
   import cspar_pkg::*;
#(
   parameter bit IS_MONO = 1'b0,
   parameter int TBL_W   = 10
)
(
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             awb_done,
   input  wire logic [2:0]       awb_result,
   output logic                  awb_start,
   output logic      [2:0]       wb_mode,
   output logic      [7:0]       red_offset,
   output logic      [7:0]       blue_offset,
   output logic                  overlay_on,
   output logic      [6:0]       coef_k0,
   output logic      [6:0]       coef_k1,
   output logic      [6:0]       coef_k2,
   output logic      [7:0]       coring_neg,
   output logic      [7:0]       coring_pos,
   output logic      [5:0]       scale_neg_out,
   output logic      [5:0]       scale_pos_out,
   output logic      [9:0]       limit_lo,
   output logic      [9:0]       limit_hi,
   output logic      [2:0]       crisp_out,
   output logic                  edge_en,
   output logic                  matrix_on,
   output logic                  mtx_we,
   output logic      [3:0]       mtx_idx,
   output logic      [9:0]       mtx_val,
   output logic      [1:0]       tone_mode,
   output logic      [10:0]      thresh_out,
   output logic                  tbl_we,
   output logic      [9:0]       tbl_addr,
   output logic      [TBL_W-1:0] tbl_data,
   output logic                  merge_on,
   output logic                  partial_en,
   output logic      [3:0]       partial_start,
   output logic      [4:0]       partial_end,
   output logic                  trig_src,
   output logic                  pattern_on,
   output logic      [2:0]       serial_speed,
   output logic      [12:0]      bit_period
);
   // ===========================================================
   // Helpers
   function automatic logic fits(input logic [1:0] n, input int k,
                                 input logic [10:0] v, input int mx);
      fits = (n < 2'(k)) || (v <= 11'(mx));
   endfunction

   function automatic logic [12:0] baud_div(input logic [2:0] s);
      case (s)
         3'd0:    baud_div = 13'(CLK_HZ / BPS0);
         3'd1:    baud_div = 13'(CLK_HZ / BPS1);
         3'd2:    baud_div = 13'(CLK_HZ / BPS2);
         3'd3:    baud_div = 13'(CLK_HZ / BPS3);
         default: baud_div = 13'(CLK_HZ / BPS4);
      endcase
   endfunction

   function automatic logic legal_op(input logic [4:0] op,
      input logic [1:0] n, input logic [10:0] a, input logic [10:0] b,
      input logic [10:0] c);
      case (op)
         OP_WB_MODE:    legal_op = !IS_MONO && fits(n, 1, a, 4);
         OP_RED_GAIN,
         OP_BLUE_GAIN:  legal_op = !IS_MONO && fits(n, 1, a, 255);
         OP_OVERLAY:    legal_op = !IS_MONO && fits(n, 1, a, 1);
         OP_ONE_PUSH:   legal_op = !IS_MONO;
         OP_COEF:       legal_op = fits(n, 1, a, 127) && fits(n, 2, b, 127)
                                   && fits(n, 3, c, 127);
         OP_CORING:     legal_op = fits(n, 1, a, 255) && fits(n, 2, b, 255);
         OP_SCALE:      legal_op = fits(n, 1, a, 63) && fits(n, 2, b, 63);
         OP_LIMIT:      legal_op = fits(n, 1, a, 1023) && fits(n, 2, b, 1023);
         OP_CRISP:      legal_op = !IS_MONO && fits(n, 1, a, 7);
         OP_EDGE_EN,
         OP_TRIG:       legal_op = fits(n, 1, a, 1);
         OP_MATRIX:     legal_op = !IS_MONO && (n == 2'd0 || (a <= 11'd2
                                   && (a != 11'(MTX_WRITE) || (n == 2'd3
                                   && b <= 11'd8 && c <= 11'd1023))));
         OP_TONE_MODE:  legal_op = fits(n, 1, a, 3);
         OP_THRESH:     legal_op = fits(n, 1, a, 1024);
         OP_TABLE,
         OP_TBL_DATA:   legal_op = fits(n, 1, a, 1023);
         OP_MERGE:      legal_op = IS_MONO && fits(n, 1, a, 1);
         OP_PARTIAL:    legal_op = fits(n, 1, a, 1) && fits(n, 2, b, 15)
                                   && fits(n, 3, c, 16);
         OP_BARS:       legal_op = !IS_MONO && fits(n, 1, a, 1);
         OP_RAMP:       legal_op = IS_MONO && fits(n, 1, a, 1);
         OP_SPEED:      legal_op = fits(n, 1, a, 4);
         OP_TBL_QUIT:   legal_op = 1'b1;
         default:       legal_op = 1'b0;
      endcase
   endfunction

   // ===========================================================
   // Bus decode
   cspar_state_t state;
   logic [10:0]  p1, p2, p3;
   logic [3:0]   reply;
   logic [7:0]   red_gain, blue_gain;
   logic [5:0]   scale_neg, scale_pos;
   logic [2:0]   crisp;
   logic [10:0]  thresh;

   wire        access   = psel && penable;
   wire        wr       = access && pwrite;
   wire        wr_cmd   = wr && paddr == CMD_OFF;
   wire [4:0]  op       = pwdata[OPC_LSB+:5];
   wire [1:0]  n        = pwdata[CNT_LSB+:2];
   wire        mapped   = paddr == CMD_OFF || paddr == P1_OFF
                          || paddr == P2_OFF || paddr == P3_OFF
                          || paddr == STAT_OFF || paddr == SET_OFF;
   // A command that lands while a run is busy is dropped unseen.
   wire        exec     = wr_cmd && state != ST_AWB;
   wire        tbl_op   = op == OP_TBL_DATA || op == OP_TBL_QUIT;
   wire [4:0]  eff_start = (n >= 2'd2) ? p2[4:0] : {1'b0, partial_start};
   wire [4:0]  eff_end   = (n == 2'd3) ? p3[4:0] : partial_end;
   wire        win_ok   = op != OP_PARTIAL || (eff_start < eff_end
                          && eff_end - eff_start < 5'(WIN_SPAN));
   // Only the last parameters may be missing, so a count says it all.
   wire        legal    = legal_op(op, n, p1, p2, p3) && win_ok
                          && ((state == ST_TBL) == tbl_op);
   wire        do_set   = exec && legal && n != 2'd0;
   wire        one_push = exec && legal && op == OP_ONE_PUSH
                          && wb_mode == WB_ONEPUSH;
   wire        enter_tb = do_set && op == OP_TABLE;

   assign pready  = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata  = !access ? 32'h0 :
                    paddr == P1_OFF   ? {21'h0, p1} :
                    paddr == P2_OFF   ? {21'h0, p2} :
                    paddr == P3_OFF   ? {21'h0, p3} :
                    paddr == STAT_OFF ? {25'h0, state, reply} :
                    paddr == SET_OFF  ? {22'h0, tbl_addr} : 32'h0;

   // ===========================================================
   // Effective outputs
   wire manual = wb_mode == WB_MANUAL;
   assign red_offset    = manual ? red_gain : 8'h00;
   assign blue_offset   = manual ? blue_gain : 8'h00;
   assign scale_neg_out = edge_en ? scale_neg : 6'h00;
   assign scale_pos_out = edge_en ? scale_pos : 6'h00;
   assign crisp_out     = edge_en ? crisp : 3'h0;
   assign thresh_out    = tone_mode == TONE_BIN ? thresh : 11'h0;
   assign bit_period    = baud_div(serial_speed);

   // ===========================================================
   // Parameter latches and sequencing
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         p1 <= 11'h0;
         p2 <= 11'h0;
         p3 <= 11'h0;
      end
      else if (wr)
      begin
         if (paddr == P1_OFF) p1 <= pwdata[10:0];
         if (paddr == P2_OFF) p2 <= pwdata[10:0];
         if (paddr == P3_OFF) p3 <= pwdata[10:0];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state     <= ST_IDLE;
         reply     <= REP_NONE;
         awb_start <= 1'b0;
      end
      else
      begin
         awb_start <= one_push;
         case (state)
            ST_IDLE:
            begin
               if (one_push) state <= ST_AWB;
               if (enter_tb) state <= ST_TBL;
            end
            ST_AWB:
            begin
               // One result per run: the done pulse is heeded only here.
               if (awb_done)
               begin
                  state <= ST_IDLE;
                  reply <= REP_AWB + {1'b0, awb_result};
               end
            end
            ST_TBL:
               if (exec && legal && op == OP_TBL_QUIT) state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
         // A one-push request outside mode 4 is ignored, so it gives no reply.
         if (exec && legal && op == OP_ONE_PUSH)
            reply <= REP_NONE;
         else if (exec)
            reply <= legal ? REP_OK : REP_SYNTAX;
      end
   end

   // ===========================================================
   // Setting store
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         wb_mode <= 3'h0; red_gain <= 8'h0; blue_gain <= 8'h0;
         overlay_on <= 1'b0; coef_k0 <= 7'h0; coef_k1 <= 7'h0;
         coef_k2 <= 7'h0; coring_neg <= 8'h0; coring_pos <= 8'h0;
         scale_neg <= 6'h0; scale_pos <= 6'h0; limit_lo <= 10'h0;
         limit_hi <= 10'h0; crisp <= 3'h0; edge_en <= 1'b0;
         matrix_on <= 1'b0; mtx_we <= 1'b0; mtx_idx <= 4'h0;
         mtx_val <= 10'h0; tone_mode <= 2'h0; thresh <= 11'h0;
         tbl_we <= 1'b0; tbl_addr <= 10'h0; tbl_data <= '0;
         merge_on <= 1'b0; partial_en <= 1'b0; partial_start <= 4'h0;
         partial_end <= PEND_RST; trig_src <= 1'b0; pattern_on <= 1'b0;
         serial_speed <= SPEED_RST;
      end
      else
      begin
         mtx_we <= 1'b0;
         tbl_we <= 1'b0;
         if (tbl_we) tbl_addr <= tbl_addr + 10'd1;
         if (do_set)
         begin
            case (op)
               OP_WB_MODE:   wb_mode <= p1[2:0];
               OP_RED_GAIN:  red_gain <= p1[7:0];
               OP_BLUE_GAIN: blue_gain <= p1[7:0];
               OP_OVERLAY:   overlay_on <= p1[0];
               OP_COEF:
               begin
                  coef_k0 <= p1[6:0];
                  if (n >= 2'd2) coef_k1 <= p2[6:0];
                  if (n == 2'd3) coef_k2 <= p3[6:0];
               end
               OP_CORING:
               begin
                  coring_neg <= p1[7:0];
                  coring_pos <= n >= 2'd2 ? p2[7:0] : p1[7:0];
               end
               OP_SCALE:
               begin
                  scale_neg <= p1[5:0];
                  scale_pos <= n >= 2'd2 ? p2[5:0] : p1[5:0];
               end
               OP_LIMIT:
               begin
                  limit_lo <= p1[9:0];
                  limit_hi <= n >= 2'd2 ? p2[9:0] : p1[9:0];
               end
               OP_CRISP:     crisp <= p1[2:0];
               OP_EDGE_EN:   edge_en <= p1[0];
               OP_MATRIX:
               begin
                  if (p1[1:0] == MTX_WRITE)
                  begin
                     mtx_we  <= 1'b1;
                     mtx_idx <= p2[3:0];
                     mtx_val <= p3[9:0];
                  end
                  else
                     matrix_on <= p1[0];
               end
               OP_TONE_MODE: tone_mode <= p1[1:0];
               OP_THRESH:    thresh <= p1;
               OP_TABLE:     tbl_addr <= p1[9:0];
               OP_TBL_DATA:
               begin
                  tbl_we   <= 1'b1;
                  tbl_data <= p1[TBL_W-1:0];
               end
               OP_MERGE:     merge_on <= p1[0];
               OP_PARTIAL:
               begin
                  partial_en    <= p1[0];
                  partial_start <= eff_start[3:0];
                  partial_end   <= eff_end;
               end
               OP_TRIG:      trig_src <= p1[0];
               OP_BARS,
               OP_RAMP:      pattern_on <= p1[0];
               OP_SPEED:     serial_speed <= p1[2:0];
               default:      ;
            endcase
         end
      end
   end

   // ===========================================================
   // Checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   busy_refuse_a: assert property (state == ST_AWB && wr_cmd && !awb_done
      |=> $stable(reply) && $stable(wb_mode)) else $error("busy cmd taken");
   onepush_gate_a: assert property (awb_start
      |-> wb_mode == WB_ONEPUSH && state == ST_AWB) else $error("bad start");
   awb_result_a: assert property (state == ST_AWB && awb_done
      |=> reply == REP_AWB + {1'b0, $past(awb_result)} && state == ST_IDLE)
      else $error("awb result lost");
   edge_off_a: assert property (do_set && op == OP_EDGE_EN && !p1[0]
      |=> scale_pos_out == 6'h0 && crisp_out == 3'h0) else $error("edge on");
   coring_copy_a: assert property (do_set && op == OP_CORING && n == 2'd1
      |=> coring_pos == coring_neg) else $error("coring not copied");
   limit_copy_a: assert property (do_set && op == OP_LIMIT && n == 2'd1
      |=> limit_hi == limit_lo) else $error("limit not copied");
   mtx_mode_a: assert property (do_set && op == OP_MATRIX && p1 == 11'd2
      |=> $stable(matrix_on) && mtx_we) else $error("matrix mode moved");
   window_ok_a: assert property (partial_start < partial_end
      && partial_end - {1'b0, partial_start} < 5'd16) else $error("bad window");
   syntax_err_a: assert property (exec && !legal
      |=> reply == REP_SYNTAX) else $error("no syntax error");

   awb_run_c: cover property (one_push ##[1:20] awb_done);
   tbl_run_c: cover property (enter_tb ##[1:60] tbl_we);
   part_set_c: cover property (do_set && op == OP_PARTIAL);
   syntax_c: cover property (exec && !legal);
endmodule

// ### verif/cspar_awb_model.sv
// White balance engine stand-in that answers each start pulse after a delay.
`timescale 1ns/1ns
module cspar_awb_model
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       awb_start,
   input  wire logic [2:0] result_sel,
   input  wire logic [7:0] delay,
   output logic            awb_done,
   output logic [2:0]      awb_result
);
   logic [7:0] cnt;
   logic       busy;
   // ==========================================================
   // Engine
   // Outside the done pulse the result toggles, so a stale value never passes.
   always @(posedge core_clk)
   begin
      awb_done <= 1'b0;
      awb_result <= ~awb_result;
      if (reset)
      begin
         busy <= 1'b0;
         awb_result <= 3'h0;
      end
      else if (awb_start)
      begin
         busy <= 1'b1;
         cnt <= delay;
      end
      else if (busy && cnt != 8'h00)
         cnt <= cnt - 8'h01;
      else if (busy)
      begin
         busy <= 1'b0;
         awb_done <= 1'b1;
         awb_result <= result_sel;
      end
   end
endmodule

// ### verif/camera_setting_command_parser_tb.sv
// Self-checking bench for the camera setting command parser.
`timescale 1ns/1ns
module camera_setting_command_parser_tb
   import cspar_pkg::*;
;
   logic        core_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic        awb_done, awb_start, overlay_on, matrix_on, mtx_we, tbl_we;
   logic        trig_src, pattern_on, last_err;
   logic        edge_en, merge_on, partial_en;
   logic [1:0]  tone_mode;
   logic [2:0]  awb_result, result_sel, crisp_out, serial_speed, wb_mode;
   logic [7:0]  paddr, delay, red_offset, coring_neg, coring_pos, blue_offset;
   logic [31:0] pwdata, prdata, q;
   logic [6:0]  coef_k0, coef_k1, coef_k2;
   logic [5:0]  scale_neg_out, scale_pos_out;
   logic [9:0]  limit_lo, limit_hi, mtx_val, tbl_addr, tbl_data;
   logic [3:0]  mtx_idx, partial_start;
   logic [4:0]  partial_end;
   logic [10:0] thresh_out;
   logic [12:0] bit_period;
   logic [13:0] mtx_seen;
   logic [19:0] tbl_seen;
   int          bad_count, num_checks, starts, n;
   int          bps [5] = '{BPS0, BPS1, BPS2, BPS3, BPS4};

   cspar_top cspar_top_inst (.core_clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .awb_done, .awb_result,
      .awb_start, .wb_mode, .red_offset, .blue_offset, .overlay_on,
      .coef_k0, .coef_k1, .coef_k2, .coring_neg, .coring_pos, .scale_neg_out,
      .scale_pos_out, .limit_lo, .limit_hi, .crisp_out, .edge_en,
      .matrix_on, .mtx_we, .mtx_idx, .mtx_val, .tone_mode, .thresh_out,
      .tbl_we, .tbl_addr, .tbl_data, .merge_on, .partial_en,
      .partial_start, .partial_end, .trig_src, .pattern_on, .serial_speed,
      .bit_period);
   cspar_awb_model cspar_awb_model_inst (.core_clk, .reset, .awb_start,
      .result_sel, .delay, .awb_done, .awb_result);

   // ==========================================================
   // Clock, pulse capture and watchdog
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      if (mtx_we === 1'b1)
         mtx_seen <= {mtx_idx, mtx_val};
      if (tbl_we === 1'b1)
         tbl_seen <= {tbl_addr, tbl_data};
      if (awb_start === 1'b1)
         starts <= starts + 1;
   end
   initial
   begin
      #2_000_000;
      bad_count++;
      tally_and_finish();
   end

   // ==========================================================
   // Tasks
   task automatic tally_and_finish();
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Holds the request until pready is seen high, as a real master must.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1)
         @(posedge core_clk);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic cmd(input logic [4:0] op, input logic [1:0] cnt,
      input logic [10:0] p1, p2, p3, input logic [3:0] rep);
      apb(1'b1, P1_OFF, {21'h0, p1});
      apb(1'b1, P2_OFF, {21'h0, p2});
      apb(1'b1, P3_OFF, {21'h0, p3});
      apb(1'b1, CMD_OFF, {22'h0, cnt, 3'h0, op});
      apb(1'b0, STAT_OFF, 32'h0);
      chk(q[3:0], rep);
   endtask

   // ==========================================================
   // Tests
   initial
   begin
      {core_clk, psel, penable, pwrite, paddr, pwdata} = '0;
      {result_sel, bad_count, num_checks, starts} = '0;
      delay = 8'h3c;
      reset = 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      apb(1'b0, STAT_OFF, 32'h0);
      chk(q, 32'h10);
      chk({serial_speed, bit_period, partial_end},
          {SPEED_RST, 13'(CLK_HZ / BPS3), 5'd15});
      apb(1'b0, 8'h20, 32'h0);
      chk(last_err, 1'b1);
      cmd(OP_ONE_PUSH, 0, 0, 0, 0, REP_NONE);
      chk({q[6:4], 4'(starts)}, {3'b001, 4'h0});
      cmd(OP_WB_MODE, 1, 3, 0, 0, REP_OK);
      chk(wb_mode, 3'h3);
      cmd(OP_RED_GAIN, 1, 11'h80, 0, 0, REP_OK);
      cmd(OP_BLUE_GAIN, 1, 11'h7f, 0, 0, REP_OK);
      chk({red_offset, blue_offset}, 16'h807f);
      cmd(OP_RED_GAIN, 1, 11'h100, 0, 0, REP_SYNTAX);
      chk(red_offset, 8'h80);
      cmd(OP_WB_MODE, 1, 1, 0, 0, REP_OK);
      chk({red_offset, blue_offset}, 16'h0);
      cmd(OP_WB_MODE, 1, 5, 0, 0, REP_SYNTAX);
      chk(wb_mode, 3'h1);
      cmd(OP_WB_MODE, 1, 4, 0, 0, REP_OK);
      for (int r = 0; r < 6; r++)
      begin
         result_sel <= 3'(r);
         delay <= (r == 0) ? 8'h3c : 8'(r);
         cmd(OP_ONE_PUSH, 0, 0, 0, 0, REP_NONE);
         if (r == 0)
         begin
            chk(q[6:4], 3'b010);
            cmd(OP_SPEED, 1, 0, 0, 0, REP_NONE);
            chk(serial_speed, SPEED_RST);
         end
         n = 0;
         do
         begin
            apb(1'b0, STAT_OFF, 32'h0);
            n++;
         end
         while (q[6:4] !== 3'b001 && n < 40);
         chk(q, {25'h0, 3'b001, 4'(8 + r)});
      end
      chk(starts, 6);
      for (int i = 0; i < 5; i++)
      begin
         cmd(OP_SPEED, 1, 11'(i), 0, 0, REP_OK);
         chk({serial_speed, bit_period},
             {3'(i), 13'(CLK_HZ / bps[i])});
      end
      cmd(OP_SPEED, 1, 5, 0, 0, REP_SYNTAX);
      chk(serial_speed, 3'h4);
      cmd(OP_COEF, 3, 1, 2, 3, REP_OK);
      cmd(OP_COEF, 1, 11'h7f, 0, 0, REP_OK);
      chk({coef_k0, coef_k1, coef_k2}, {7'h7f, 7'h02, 7'h03});
      cmd(OP_CORING, 1, 11'hff, 0, 0, REP_OK);
      chk({coring_neg, coring_pos}, 16'hffff);
      cmd(OP_EDGE_EN, 1, 1, 0, 0, REP_OK);
      chk(edge_en, 1'b1);
      cmd(OP_SCALE, 1, 11'h3f, 0, 0, REP_OK);
      cmd(OP_CRISP, 1, 7, 0, 0, REP_OK);
      chk({scale_neg_out, scale_pos_out, crisp_out}, 15'h7fff);
      cmd(OP_CRISP, 1, 8, 0, 0, REP_SYNTAX);
      cmd(OP_EDGE_EN, 1, 0, 0, 0, REP_OK);
      chk(edge_en, 1'b0);
      chk({scale_neg_out, scale_pos_out, crisp_out}, 15'h0);
      cmd(OP_LIMIT, 1, 11'h3ff, 0, 0, REP_OK);
      chk({limit_lo, limit_hi}, 20'hfffff);
      cmd(OP_MATRIX, 1, 1, 0, 0, REP_OK);
      cmd(OP_MATRIX, 3, 2, 8, 11'h3ff, REP_OK);
      chk({matrix_on, mtx_seen}, {1'b1, 4'h8, 10'h3ff});
      cmd(OP_MATRIX, 3, 2, 9, 0, REP_SYNTAX);
      cmd(OP_TONE_MODE, 1, 11'(TONE_BIN), 0, 0, REP_OK);
      cmd(OP_THRESH, 1, 1024, 0, 0, REP_OK);
      chk({tone_mode, thresh_out}, {TONE_BIN, 11'd1024});
      cmd(OP_THRESH, 1, 1025, 0, 0, REP_SYNTAX);
      cmd(OP_TONE_MODE, 1, 2, 0, 0, REP_OK);
      chk({tone_mode, thresh_out}, {2'h2, 11'd0});
      cmd(OP_TONE_MODE, 1, 0, 0, 0, REP_OK);
      chk({tone_mode, thresh_out}, 13'h0);
      cmd(OP_TBL_DATA, 1, 5, 0, 0, REP_SYNTAX);
      cmd(OP_TABLE, 1, 1023, 0, 0, REP_OK);
      chk({q[6:4], tbl_addr}, {3'b100, 10'h3ff});
      cmd(OP_SPEED, 1, 0, 0, 0, REP_SYNTAX);
      cmd(OP_TBL_DATA, 1, 11'h2aa, 0, 0, REP_OK);
      chk(tbl_seen, {10'h3ff, 10'h2aa});
      cmd(OP_TBL_QUIT, 0, 0, 0, 0, REP_OK);
      chk(q[6:4], 3'b001);
      cmd(OP_MERGE, 1, 1, 0, 0, REP_SYNTAX);
      chk(merge_on, 1'b0);
      cmd(OP_RAMP, 1, 1, 0, 0, REP_SYNTAX);
      cmd(OP_PARTIAL, 3, 1, 0, 15, REP_OK);
      cmd(OP_PARTIAL, 3, 1, 0, 16, REP_SYNTAX);
      cmd(OP_PARTIAL, 3, 1, 5, 4, REP_SYNTAX);
      cmd(OP_PARTIAL, 2, 1, 3, 0, REP_OK);
      chk({partial_en, partial_start, partial_end}, {1'b1, 4'h3, 5'd15});
      cmd(OP_TRIG, 1, 1, 0, 0, REP_OK);
      cmd(OP_BARS, 1, 1, 0, 0, REP_OK);
      cmd(OP_OVERLAY, 1, 1, 0, 0, REP_OK);
      chk({trig_src, pattern_on, overlay_on}, 3'b111);
      tally_and_finish();
   end
endmodule
